/* File: include/ued_pkg.sv */
// constants for the device endpoint and transaction control block
package ued_pkg;
  // register indices (word addresses on the register port)
  localparam logic [7:0] A_DEV_STAT   = 8'h00;
  localparam logic [7:0] A_SETUP_CTL  = 8'h01;
  localparam logic [7:0] A_EP0_CTL    = 8'h02;
  localparam logic [7:0] A_DESC_ADDR  = 8'h04;
  localparam logic [7:0] A_DESC_LEN   = 8'h05;
  localparam logic [7:0] A_AREA_CLR   = 8'h06;
  localparam logic [7:0] A_DEV_IEN    = 8'h07;
  localparam logic [7:0] A_UCTL       = 8'h08;
  localparam logic [7:0] A_UCTL_LAST  = 8'h0e;
  localparam logic [7:0] A_ECFG       = 8'h11;
  localparam logic [7:0] A_ECFG_LAST  = 8'h15;
  localparam logic [7:0] A_MAXP       = 8'h18;
  localparam logic [7:0] A_MAXP_LAST  = 8'h1d;
  localparam logic [7:0] A_STAT       = 8'h20;
  localparam logic [7:0] A_STAT_LAST  = 8'h25;
  localparam logic [7:0] A_IEN        = 8'h28;
  localparam logic [7:0] A_IEN_LAST   = 8'h2d;
  localparam logic [7:0] A_ALM        = 8'h30;
  localparam logic [7:0] A_ALM_LAST   = 8'h33;
  localparam logic [7:0] A_HIT_IN     = 8'h34;
  localparam logic [7:0] A_HIT_OUT    = 8'h35;
  localparam logic [7:0] A_AST        = 8'h40;
  localparam logic [7:0] A_AST_LAST   = 8'h45;
  localparam logic [7:0] A_AEND       = 8'h48;
  localparam logic [7:0] A_AEND_LAST  = 8'h4d;
  localparam logic [7:0] A_AJOIN      = 8'h50;
  localparam logic [7:0] A_AJOIN_LAST = 8'h55;
  localparam logic [7:0] A_SDATA      = 8'h58;
  localparam logic [7:0] A_SDATA_LAST = 8'h5b;
  // unit control bits
  localparam int UB_NAK = 0, UB_HALT = 1, UB_SHORT = 2, UB_ANAK = 3;
  localparam int UB_TOG = 4, UB_TSET = 5, UB_TCLR = 6, UB_INH = 7;
  // general endpoint configuration bits, id in 3:0
  localparam int CF_DIR = 4, CF_INTMODE = 5, CF_ISO = 6;
  // per endpoint result flags
  localparam int ST_RXSHORT = 0, ST_TXACK = 1, ST_RXACK = 2, ST_TXNAK = 3;
  localparam int ST_RXNAK = 4, ST_TXERR = 5, ST_RXERR = 6, ST_DESC = 7;
  // control endpoint bits
  localparam int C_DIR = 0, C_AUTO = 1;
  // units: 0 control out, 1-5 general, 6 control in
  localparam logic [2:0] UNIT_CIN  = 3'h6;
  localparam logic [2:0] UNIT_NONE = 3'h7;
  localparam logic [2:0] JOIN_NONE = 3'h7;
  // reset values
  localparam logic [10:0] RST_MAXP = 11'h008;
  localparam logic [15:0] RST_ZERO = 16'h0000;
  // token kinds from the packet engine
  localparam logic [1:0] TOK_OUT = 2'h0, TOK_IN = 2'h1, TOK_SETUP = 2'h2, TOK_PING = 2'h3;
  // handshake reply codes
  localparam logic [2:0] RP_NONE = 3'h0, RP_ACK = 3'h1, RP_NAK = 3'h2;
  localparam logic [2:0] RP_STALL = 3'h3, RP_DATA = 3'h4;
  typedef enum logic [1:0] {X_IDLE = 2'b01, X_BUSY = 2'b10} ued_xact_e;
endpackage

/* File: logic/ued_ctrl.sv */
// endpoint and transaction control for the device port
`timescale 1ns/1ps
// What this block does
// RULE_01: one control plus five general endpoints
// RULE_02: unheld enabled numbers answer NAK, flagged; numbers with their iso bit set get no reply here
// RULE_03: control endpoint shares set; firmware sets direction
// RULE_04: firmware picks control max packet size
// RULE_05: no control transfer before area join
// RULE_06: firmware sizes areas above max packet
// RULE_07: unjoined general endpoints run no transactions
// RULE_08: general endpoint holds direction and number
// RULE_09: firmware picks legal general packet sizes
// RULE_10: firmware sets interrupt toggle mode bit
// RULE_11: firmware sets isochronous bit for isochronous
// RULE_12: alarm enables and iso bits per number
// RULE_13: replies from fifo state, reports each transaction
// RULE_14: auto reply returns programmed bytes and address
// RULE_15: auto reply completion raises its own flag
// RULE_16: setup sets protect; protect blocks nak, halt
// RULE_17: short send enable self clears after send
// RULE_18: toggle readable, set/clear; setup reinitialises
// RULE_19: forced nak answers NAK, including ping
// RULE_20: forced halt answers STALL, including ping
// RULE_21: auto nak sets forced nak after out
// RULE_22: short out sets forced nak unless inhibited; the control out unit never sets it
// RULE_23: separate result flags plus setup flag
// RULE_24: setup stores bytes, acks, rearms control bits
// RULE_25: stall beats nak beats fifo decision
// RULE_26: flags stay until written one, gated
module ued_ctrl (
  input  wire logic          i_clock,
  input  wire logic          i_reset_n,
  input  wire logic [7:0]    i_addr,
  input  wire logic [15:0]   i_wdata,
  input  wire logic          i_wr,
  input  wire logic          i_rd,
  output logic      [15:0]   o_rdata,
  input  wire logic          i_tok_valid,
  input  wire logic [1:0]    i_tok_pid,
  input  wire logic [3:0]    i_tok_ep,
  output logic               o_reply_valid,
  output logic      [2:0]    o_reply_code,
  output logic      [2:0]    o_reply_area,
  output logic               o_reply_auto,
  input  wire logic          i_setup_byte_valid,
  input  wire logic [7:0]    i_setup_byte,
  input  wire logic          i_setup_done,
  input  wire logic          i_xfer_done,
  input  wire logic          i_xfer_error,
  input  wire logic          i_xfer_short,
  input  wire logic          i_desc_done,
  input  wire logic [5:0]    i_area_has_pkt,
  input  wire logic [5:0]    i_area_has_room,
  output logic      [5:0]    o_area_clear,
  output logic      [191:0]  o_area_bounds,
  output logic      [65:0]   o_max_packet,
  output logic      [15:0]   o_auto_reply_addr,
  output logic      [15:0]   o_auto_reply_len,
  output logic               o_irq
);
  logic [6:0]  nak_q, halt_q, short_q, anak_q, tog_q, inh_q;
  logic [6:0]  cfg_q [5];
  logic [10:0] maxp_q [6];
  logic [7:0]  stat_q [6];
  logic [7:0]  ien_q [6];
  logic [15:0] alm_q [4];
  logic [15:0] hit_in_q, hit_out_q;
  logic [15:0] ast_q [6];
  logic [15:0] aend_q [6];
  logic [2:0]  join_q [6];
  logic [7:0]  sbuf_q [8];
  logic [2:0]  sidx_q;
  logic        setup_flag_q, protect_q;
  logic [1:0]  ep0_ctl_q, dev_ien_q;
  logic [15:0] desc_addr_q, desc_len_q;
  logic [5:0]  aclr_q;
  logic [15:0] rdata_q;
  ued_pkg::ued_xact_e xs_q;
  logic [2:0]  cur_u_q, cur_ep_q;
  logic        cur_in_q;
  logic [2:0]  unit_c, ep_c, area_c, code_c;
  logic        is_in_c, alarm_c;
  logic [2:0]  wu;
  logic        wr_unit, rx_short_c;

  // control in unit shares the control endpoint's status and area
  function automatic logic [2:0] ep_of(input logic [2:0] u);
    return (u == ued_pkg::UNIT_CIN) ? 3'h0 : u;
  endfunction

  function automatic logic in_rng(input logic [7:0] a, input logic [7:0] lo,
                                  input logic [7:0] hi);
    return (a >= lo) && (a <= hi);
  endfunction

  // endpoint lookup, area lookup and reply choice for a token
  always_comb begin
    is_in_c = (i_tok_pid == ued_pkg::TOK_IN);
    unit_c  = ued_pkg::UNIT_NONE;
    if (i_tok_ep == 4'h0) begin
      unit_c = is_in_c ? ued_pkg::UNIT_CIN : 3'h0;
    end else begin
      for (int g = 0; g < 5; g++) begin
        if (unit_c == ued_pkg::UNIT_NONE && cfg_q[g][3:0] == i_tok_ep &&
            cfg_q[g][ued_pkg::CF_DIR] == is_in_c) begin
          unit_c = 3'(g + 1); // RULE_08
        end
      end
    end
    ep_c   = ep_of(unit_c);
    area_c = ued_pkg::JOIN_NONE;
    for (int a = 0; a < 6; a++) begin
      if (unit_c != ued_pkg::UNIT_NONE && join_q[a] == ep_c) begin
        area_c = 3'(a);
      end
    end
    alarm_c = 1'b0;
    code_c  = ued_pkg::RP_NONE;
    if (i_tok_pid == ued_pkg::TOK_SETUP) begin
      code_c = (i_tok_ep == 4'h0) ? ued_pkg::RP_ACK : ued_pkg::RP_NONE; // RULE_24
    end else if (unit_c == ued_pkg::UNIT_NONE) begin
      alarm_c = is_in_c ? alm_q[0][i_tok_ep] : alm_q[1][i_tok_ep]; // RULE_02
      if (alarm_c && !(is_in_c ? alm_q[2][i_tok_ep] : alm_q[3][i_tok_ep])) begin
        code_c = ued_pkg::RP_NAK; // RULE_12
      end
    end else if (area_c == ued_pkg::JOIN_NONE) begin
      code_c = ued_pkg::RP_NONE; // RULE_05 RULE_07
    end else if (halt_q[unit_c]) begin
      code_c = ued_pkg::RP_STALL; // RULE_20 RULE_25
    end else if (nak_q[unit_c]) begin
      code_c = ued_pkg::RP_NAK; // RULE_19 RULE_25
    end else if (ep_c == 3'h0 && ep0_ctl_q[ued_pkg::C_DIR] != is_in_c) begin
      code_c = ued_pkg::RP_NAK; // RULE_03
    end else if (is_in_c) begin
      if (i_area_has_pkt[area_c] || short_q[unit_c] ||
          (unit_c == ued_pkg::UNIT_CIN && ep0_ctl_q[ued_pkg::C_AUTO])) begin
        code_c = ued_pkg::RP_DATA; // RULE_13 RULE_14
      end else begin
        code_c = ued_pkg::RP_NAK;
      end
    end else begin
      code_c = i_area_has_room[area_c] ? ued_pkg::RP_ACK : ued_pkg::RP_NAK; // RULE_13
    end
  end

  // reply to the packet engine and the transaction in progress
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_reply_valid <= 1'b0;
      o_reply_code  <= ued_pkg::RP_NONE;
      o_reply_area  <= ued_pkg::JOIN_NONE;
      o_reply_auto  <= 1'b0;
      xs_q          <= ued_pkg::X_IDLE;
      cur_u_q       <= ued_pkg::UNIT_NONE;
      cur_ep_q      <= 3'h0;
      cur_in_q      <= 1'b0;
    end else begin
      o_reply_valid <= i_tok_valid;
      if (i_tok_valid) begin
        o_reply_code <= code_c;
        o_reply_area <= area_c;
        o_reply_auto <= (unit_c == ued_pkg::UNIT_CIN) && ep0_ctl_q[ued_pkg::C_AUTO]; // RULE_14
        cur_u_q      <= unit_c;
        cur_ep_q     <= ep_c;
        cur_in_q     <= is_in_c;
      end
      case (xs_q)
        ued_pkg::X_IDLE: begin
          if (i_tok_valid && i_tok_pid != ued_pkg::TOK_SETUP && i_tok_pid != ued_pkg::TOK_PING &&
              (code_c == ued_pkg::RP_ACK || code_c == ued_pkg::RP_DATA)) begin
            xs_q <= ued_pkg::X_BUSY;
          end
        end
        ued_pkg::X_BUSY: begin
          if (i_xfer_done) begin
            xs_q <= ued_pkg::X_IDLE;
          end
        end
        default: xs_q <= ued_pkg::X_IDLE;
      endcase
    end
  end

  assign wu         = 3'(i_addr - ued_pkg::A_UCTL);
  assign wr_unit    = i_wr && in_rng(i_addr, ued_pkg::A_UCTL, ued_pkg::A_UCTL_LAST);
  assign rx_short_c = (xs_q == ued_pkg::X_BUSY) && i_xfer_done && !i_xfer_error && !cur_in_q &&
                      i_xfer_short;

  // unit control bits: cpu writes, setup rearm and transaction completion
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      nak_q   <= 7'h00;
      halt_q  <= 7'h00;
      short_q <= 7'h00;
      anak_q  <= 7'h00;
      tog_q   <= 7'h00;
      inh_q   <= 7'h00;
    end else begin
      if (wr_unit) begin
        if (!(protect_q && (wu == 3'h0 || wu == ued_pkg::UNIT_CIN))) begin
          nak_q[wu]  <= i_wdata[ued_pkg::UB_NAK]; // RULE_16
          halt_q[wu] <= i_wdata[ued_pkg::UB_HALT];
        end
        short_q[wu] <= i_wdata[ued_pkg::UB_SHORT]; // RULE_17
        anak_q[wu]  <= i_wdata[ued_pkg::UB_ANAK];
        inh_q[wu]   <= i_wdata[ued_pkg::UB_INH];
        if (i_wdata[ued_pkg::UB_TSET]) begin
          tog_q[wu] <= 1'b1; // RULE_18
        end else if (i_wdata[ued_pkg::UB_TCLR]) begin
          tog_q[wu] <= 1'b0; // RULE_18
        end
      end
      if (xs_q == ued_pkg::X_BUSY && i_xfer_done && !i_xfer_error) begin
        tog_q[cur_u_q] <= ~tog_q[cur_u_q];
        if (cur_in_q && i_xfer_short) begin
          short_q[cur_u_q] <= 1'b0; // RULE_17
          if (cur_u_q == ued_pkg::UNIT_CIN) begin
            nak_q[cur_u_q] <= 1'b1;
          end
        end
        if (!cur_in_q && anak_q[cur_u_q]) begin
          nak_q[cur_u_q] <= 1'b1; // RULE_21
        end
        if (rx_short_c && cur_u_q != 3'h0 && !inh_q[cur_u_q]) begin
          nak_q[cur_u_q] <= 1'b1; // RULE_22
        end
      end
      if (i_setup_done) begin
        nak_q[0]                  <= 1'b1; // RULE_24
        nak_q[ued_pkg::UNIT_CIN]  <= 1'b1;
        halt_q[0]                 <= 1'b0;
        halt_q[ued_pkg::UNIT_CIN] <= 1'b0;
        tog_q[0]                  <= 1'b1; // RULE_18
        tog_q[ued_pkg::UNIT_CIN]  <= 1'b1;
      end
    end
  end

  // setup packet capture and the protect bit
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      sidx_q    <= 3'h0;
      protect_q <= 1'b0;
      for (int i = 0; i < 8; i++) begin
        sbuf_q[i] <= 8'h00;
      end
    end else begin
      if (i_setup_byte_valid) begin
        sbuf_q[sidx_q] <= i_setup_byte; // RULE_24
        sidx_q         <= sidx_q + 3'h1;
      end
      if (i_setup_done) begin
        sidx_q    <= 3'h0;
        protect_q <= 1'b1; // RULE_16
      end else if (i_wr && i_addr == ued_pkg::A_SETUP_CTL && !i_wdata[0]) begin
        protect_q <= 1'b0; // RULE_16
      end
    end
  end

  // sticky result flags: hardware set wins over a write-one clear
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      setup_flag_q <= 1'b0;
      hit_in_q     <= ued_pkg::RST_ZERO;
      hit_out_q    <= ued_pkg::RST_ZERO;
      for (int e = 0; e < 6; e++) begin
        stat_q[e] <= 8'h00;
      end
    end else begin
      if (i_wr && in_rng(i_addr, ued_pkg::A_STAT, ued_pkg::A_STAT_LAST)) begin
        stat_q[3'(i_addr - ued_pkg::A_STAT)] <= stat_q[3'(i_addr - ued_pkg::A_STAT)] &
                                                ~i_wdata[7:0]; // RULE_26
      end
      if (i_wr && i_addr == ued_pkg::A_DEV_STAT && i_wdata[0]) begin
        setup_flag_q <= 1'b0;
      end
      if (i_wr && i_addr == ued_pkg::A_HIT_IN) begin
        hit_in_q <= hit_in_q & ~i_wdata;
      end
      if (i_wr && i_addr == ued_pkg::A_HIT_OUT) begin
        hit_out_q <= hit_out_q & ~i_wdata;
      end
      if (i_tok_valid && unit_c != ued_pkg::UNIT_NONE && code_c == ued_pkg::RP_NAK) begin
        stat_q[ep_c][is_in_c ? ued_pkg::ST_TXNAK : ued_pkg::ST_RXNAK] <= 1'b1; // RULE_23
      end
      if (i_tok_valid && unit_c == ued_pkg::UNIT_NONE && alarm_c) begin
        if (is_in_c) begin
          hit_in_q[i_tok_ep] <= 1'b1; // RULE_02
        end else begin
          hit_out_q[i_tok_ep] <= 1'b1; // RULE_02
        end
      end
      if (xs_q == ued_pkg::X_BUSY && i_xfer_done) begin
        if (i_xfer_error) begin
          stat_q[cur_ep_q][cur_in_q ? ued_pkg::ST_TXERR : ued_pkg::ST_RXERR] <= 1'b1; // RULE_23
        end else begin
          stat_q[cur_ep_q][cur_in_q ? ued_pkg::ST_TXACK : ued_pkg::ST_RXACK] <= 1'b1; // RULE_13
        end
        if (rx_short_c) begin
          stat_q[cur_ep_q][ued_pkg::ST_RXSHORT] <= 1'b1; // RULE_23
        end
      end
      if (i_desc_done) begin
        stat_q[0][ued_pkg::ST_DESC] <= 1'b1; // RULE_15
      end
      if (i_setup_done) begin
        setup_flag_q <= 1'b1; // RULE_23
      end
    end
  end

  // configuration registers written by software
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ep0_ctl_q   <= 2'h0;
      dev_ien_q   <= 2'h0;
      desc_addr_q <= ued_pkg::RST_ZERO;
      desc_len_q  <= ued_pkg::RST_ZERO;
      aclr_q      <= 6'h00;
      for (int i = 0; i < 6; i++) begin
        maxp_q[i] <= ued_pkg::RST_MAXP;
        ien_q[i]  <= 8'h00;
        ast_q[i]  <= ued_pkg::RST_ZERO;
        aend_q[i] <= ued_pkg::RST_ZERO;
        join_q[i] <= ued_pkg::JOIN_NONE;
      end
      for (int i = 0; i < 5; i++) begin
        cfg_q[i] <= 7'h00;
      end
      for (int i = 0; i < 4; i++) begin
        alm_q[i] <= ued_pkg::RST_ZERO;
      end
    end else begin
      aclr_q <= 6'h00;
      if (i_wr) begin
        if (i_addr == ued_pkg::A_EP0_CTL) begin
          ep0_ctl_q <= i_wdata[1:0]; // RULE_03 RULE_14
        end else if (i_addr == ued_pkg::A_DEV_IEN) begin
          dev_ien_q <= i_wdata[1:0];
        end else if (i_addr == ued_pkg::A_DESC_ADDR) begin
          desc_addr_q <= i_wdata;
        end else if (i_addr == ued_pkg::A_DESC_LEN) begin
          desc_len_q <= i_wdata;
        end else if (i_addr == ued_pkg::A_AREA_CLR) begin
          aclr_q <= i_wdata[5:0];
        end else if (in_rng(i_addr, ued_pkg::A_ECFG, ued_pkg::A_ECFG_LAST)) begin
          cfg_q[3'(i_addr - ued_pkg::A_ECFG)] <= i_wdata[6:0]; // RULE_01 RULE_08
        end else if (in_rng(i_addr, ued_pkg::A_MAXP, ued_pkg::A_MAXP_LAST)) begin
          maxp_q[3'(i_addr - ued_pkg::A_MAXP)] <= i_wdata[10:0];
        end else if (in_rng(i_addr, ued_pkg::A_IEN, ued_pkg::A_IEN_LAST)) begin
          ien_q[3'(i_addr - ued_pkg::A_IEN)] <= i_wdata[7:0];
        end else if (in_rng(i_addr, ued_pkg::A_ALM, ued_pkg::A_ALM_LAST)) begin
          alm_q[2'(i_addr - ued_pkg::A_ALM)] <= i_wdata & 16'hfffe; // RULE_12
        end else if (in_rng(i_addr, ued_pkg::A_AST, ued_pkg::A_AST_LAST)) begin
          ast_q[3'(i_addr - ued_pkg::A_AST)] <= i_wdata;
        end else if (in_rng(i_addr, ued_pkg::A_AEND, ued_pkg::A_AEND_LAST)) begin
          aend_q[3'(i_addr - ued_pkg::A_AEND)] <= i_wdata;
        end else if (in_rng(i_addr, ued_pkg::A_AJOIN, ued_pkg::A_AJOIN_LAST)) begin
          join_q[3'(i_addr - ued_pkg::A_AJOIN)] <= i_wdata[2:0]; // RULE_05
        end
      end
    end
  end

  // read data one cycle after the strobe, zero for unmapped words
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rdata_q <= ued_pkg::RST_ZERO;
    end else if (i_rd) begin
      rdata_q <= ued_pkg::RST_ZERO;
      if (i_addr == ued_pkg::A_DEV_STAT) begin
        rdata_q <= {15'h0000, setup_flag_q};
      end else if (i_addr == ued_pkg::A_SETUP_CTL) begin
        rdata_q <= {15'h0000, protect_q};
      end else if (i_addr == ued_pkg::A_EP0_CTL) begin
        rdata_q <= {14'h0000, ep0_ctl_q};
      end else if (i_addr == ued_pkg::A_DESC_ADDR) begin
        rdata_q <= desc_addr_q;
      end else if (i_addr == ued_pkg::A_DESC_LEN) begin
        rdata_q <= desc_len_q;
      end else if (i_addr == ued_pkg::A_DEV_IEN) begin
        rdata_q <= {14'h0000, dev_ien_q};
      end else if (in_rng(i_addr, ued_pkg::A_UCTL, ued_pkg::A_UCTL_LAST)) begin
        rdata_q <= {8'h00, inh_q[wu], 2'b00, tog_q[wu], anak_q[wu], short_q[wu],
                    halt_q[wu], nak_q[wu]}; // RULE_18
      end else if (in_rng(i_addr, ued_pkg::A_ECFG, ued_pkg::A_ECFG_LAST)) begin
        rdata_q <= {9'h000, cfg_q[3'(i_addr - ued_pkg::A_ECFG)]};
      end else if (in_rng(i_addr, ued_pkg::A_MAXP, ued_pkg::A_MAXP_LAST)) begin
        rdata_q <= {5'h00, maxp_q[3'(i_addr - ued_pkg::A_MAXP)]};
      end else if (in_rng(i_addr, ued_pkg::A_STAT, ued_pkg::A_STAT_LAST)) begin
        rdata_q <= {8'h00, stat_q[3'(i_addr - ued_pkg::A_STAT)]};
      end else if (in_rng(i_addr, ued_pkg::A_IEN, ued_pkg::A_IEN_LAST)) begin
        rdata_q <= {8'h00, ien_q[3'(i_addr - ued_pkg::A_IEN)]};
      end else if (in_rng(i_addr, ued_pkg::A_ALM, ued_pkg::A_ALM_LAST)) begin
        rdata_q <= alm_q[2'(i_addr - ued_pkg::A_ALM)];
      end else if (i_addr == ued_pkg::A_HIT_IN) begin
        rdata_q <= hit_in_q;
      end else if (i_addr == ued_pkg::A_HIT_OUT) begin
        rdata_q <= hit_out_q;
      end else if (in_rng(i_addr, ued_pkg::A_AST, ued_pkg::A_AST_LAST)) begin
        rdata_q <= ast_q[3'(i_addr - ued_pkg::A_AST)];
      end else if (in_rng(i_addr, ued_pkg::A_AEND, ued_pkg::A_AEND_LAST)) begin
        rdata_q <= aend_q[3'(i_addr - ued_pkg::A_AEND)];
      end else if (in_rng(i_addr, ued_pkg::A_AJOIN, ued_pkg::A_AJOIN_LAST)) begin
        rdata_q <= {13'h0000, join_q[3'(i_addr - ued_pkg::A_AJOIN)]};
      end else if (in_rng(i_addr, ued_pkg::A_SDATA, ued_pkg::A_SDATA_LAST)) begin
        rdata_q <= {sbuf_q[{i_addr[1:0], 1'b1}], sbuf_q[{i_addr[1:0], 1'b0}]};
      end
    end else begin
      rdata_q <= ued_pkg::RST_ZERO;
    end
  end

  // interrupt summary of enabled flags
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= (setup_flag_q && dev_ien_q[0]) ||
               (dev_ien_q[1] && (|hit_in_q || |hit_out_q)) ||
               |(stat_q[0] & ien_q[0]) || |(stat_q[1] & ien_q[1]) ||
               |(stat_q[2] & ien_q[2]) || |(stat_q[3] & ien_q[3]) ||
               |(stat_q[4] & ien_q[4]) || |(stat_q[5] & ien_q[5]); // RULE_26
    end
  end

  always_comb begin
    for (int i = 0; i < 6; i++) begin
      o_area_bounds[i*32 +: 32] = {aend_q[i], ast_q[i]};
      o_max_packet[i*11 +: 11]  = maxp_q[i];
    end
  end

  assign o_rdata           = rdata_q;
  assign o_area_clear      = aclr_q;
  assign o_auto_reply_addr = desc_addr_q;
  assign o_auto_reply_len  = desc_len_q;
endmodule // ued_ctrl

/* File: dv/ued_host_model.sv */
// host model: issues tokens and finishes accepted transfers
`timescale 1ns/1ps
module ued_host_model (
  input  wire logic       i_clock,
  input  wire logic       i_reply_valid,
  input  wire logic [2:0] i_reply_code,
  output logic            o_tok_valid = 1'b0,
  output logic      [1:0] o_tok_pid = 2'h0,
  output logic      [3:0] o_tok_ep = 4'h0,
  output logic            o_xfer_done = 1'b0
);
  task automatic token(input logic [1:0] p, input logic [3:0] e, output logic [2:0] c);
    @(posedge i_clock);
    o_tok_valid <= 1'b1;
    o_tok_pid   <= p;
    o_tok_ep    <= e;
    @(posedge i_clock);
    o_tok_valid <= 1'b0;
    o_tok_ep    <= ~e;
    #1 c = i_reply_valid ? i_reply_code : 3'h7;
    if (!p[1] && (c == 3'h1 || c == 3'h4)) begin
      @(posedge i_clock);
      o_xfer_done <= 1'b1;
      @(posedge i_clock);
      o_xfer_done <= 1'b0;
    end
  endtask
endmodule // ued_host_model

/* File: dv/ued_ctrl_checker.sv */
// port assertions for the endpoint control block
`timescale 1ns/1ps
module ued_ctrl_checker (
  input wire logic        i_clock,
  input wire logic        i_reset_n,
  input wire logic [7:0]  i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic        i_wr,
  input wire logic        i_tok_valid,
  input wire logic [1:0]  i_tok_pid,
  input wire logic [3:0]  i_tok_ep,
  input wire logic        i_setup_done,
  input wire logic        o_reply_valid,
  input wire logic [2:0]  o_reply_code,
  input wire logic [5:0]  o_area_clear,
  input wire logic [15:0] o_auto_reply_addr
);
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_reset_n);
  sequence s_ctl_out;
    i_tok_valid && i_tok_pid == 2'h0 && i_tok_ep == 4'h0;
  endsequence
  sequence s_setup_out;
    i_setup_done ##[1:2] s_ctl_out;
  endsequence
  property p_reply; i_tok_valid |=> o_reply_valid; endproperty
  a_reply: assert property (p_reply) else $error("reply late");
  property p_cause; o_reply_valid |-> $past(i_tok_valid); endproperty
  a_cause: assert property (p_cause) else $error("stray reply");
  property p_hold; !i_tok_valid |=> $stable(o_reply_code); endproperty
  a_hold: assert property (p_hold) else $error("reply moved");
  property p_sack;
    i_tok_valid && i_tok_pid == 2'h2 && i_tok_ep == 4'h0 |=> o_reply_code == 3'h1;
  endproperty
  a_sack: assert property (p_sack) else $error("setup not acked");
  property p_snak; s_setup_out |=> o_reply_code inside {3'h0, 3'h2}; endproperty
  a_snak: assert property (p_snak) else $error("control not naked");
  property p_clr; i_wr && i_addr == 8'h06 |=> o_area_clear == $past(i_wdata[5:0]); endproperty
  a_clr: assert property (p_clr) else $error("area clear lost");
  property p_clrsrc; o_area_clear != 6'h00 |-> $past(i_wr) && $past(i_addr) == 8'h06; endproperty
  a_clrsrc: assert property (p_clrsrc) else $error("stray clear");
  property p_desc; i_wr && i_addr == 8'h04 |=> o_auto_reply_addr == $past(i_wdata); endproperty
  a_desc: assert property (p_desc) else $error("reply address lost");
endmodule // ued_ctrl_checker
bind ued_ctrl ued_ctrl_checker ued_ctrl_checker_i (.i_clock, .i_reset_n, .i_addr, .i_wdata,
  .i_wr, .i_tok_valid, .i_tok_pid, .i_tok_ep, .i_setup_done, .o_reply_valid, .o_reply_code,
  .o_area_clear, .o_auto_reply_addr);

/* File: dv/ued_ctrl_tb_top.sv */
// self-checking bench for the endpoint control block
`timescale 1ns/1ps
module ued_ctrl_tb_top;
  logic        i_clock = 1'b0, i_reset_n = 1'b0, i_wr = 1'b0, i_rd = 1'b0;
  logic        i_setup_byte_valid = 1'b0, i_setup_done = 1'b0, i_desc_done = 1'b0;
  logic [7:0]  i_addr = 8'h00, i_setup_byte = 8'h00;
  logic [15:0] i_wdata = 16'h0000, o_rdata;
  logic [5:0]  i_area_has_pkt = 6'h00, i_area_has_room = 6'h3f;
  logic        i_tok_valid, i_xfer_done, o_reply_valid, o_irq, o_reply_auto;
  logic [1:0]  i_tok_pid;
  logic [3:0]  i_tok_ep;
  logic [2:0]  o_reply_code, o_reply_area, c;
  logic [191:0] o_area_bounds;
  logic [65:0]  o_max_packet;
  int          miscompares = 0, check_count = 0;
  always #10 i_clock = ~i_clock;
  ued_ctrl ued_ctrl_i (.i_clock, .i_reset_n, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
    .i_tok_valid, .i_tok_pid, .i_tok_ep, .o_reply_valid, .o_reply_code, .o_reply_area,
    .o_reply_auto, .i_setup_byte_valid, .i_setup_byte, .i_setup_done, .i_xfer_done,
    .i_xfer_error(1'b0), .i_xfer_short(1'b1), .i_desc_done, .i_area_has_pkt,
    .i_area_has_room, .o_area_clear(), .o_area_bounds, .o_max_packet,
    .o_auto_reply_addr(), .o_auto_reply_len(), .o_irq);
  ued_host_model ued_host_model_i (.i_clock, .i_reply_valid(o_reply_valid),
    .i_reply_code(o_reply_code), .o_tok_valid(i_tok_valid), .o_tok_pid(i_tok_pid),
    .o_tok_ep(i_tok_ep), .o_xfer_done(i_xfer_done));
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    check_count++;
    if (g !== e) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge i_clock);
    i_wr    <= 1'b1;
    i_addr  <= a;
    i_wdata <= d;
    @(posedge i_clock);
    i_wr    <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] m, input logic [15:0] e);
    @(posedge i_clock);
    i_rd   <= 1'b1;
    i_addr <= a;
    @(posedge i_clock);
    i_rd   <= 1'b0;
    #1 chk("rdata", e, o_rdata & m);
  endtask
  task automatic tok(input logic [1:0] p, input logic [3:0] ep, input logic [2:0] x);
    ued_host_model_i.token(p, ep, c);
    chk("reply", {13'h0000, x}, {13'h0000, c});
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    #100000 miscompares++;
    wrap_up;
  end
  initial begin
    repeat (6) @(posedge i_clock);
    i_reset_n <= 1'b1;
    rd(8'h50, 16'hffff, 16'h0007);
    tok(2'h0, 4'h0, 3'h0);
    wr(8'h48, 16'h003f);
    wr(8'h19, 16'h0040);
    #1 chk("bounds", 16'h003f, o_area_bounds[31:16]);
    chk("maxp", 16'h0040, {5'h00, o_max_packet[21:11]});
    wr(8'h06, 16'h003f);
    wr(8'h50, 16'h0000);
    wr(8'h04, 16'h0123);
    tok(2'h2, 4'h0, 3'h1);
    for (int k = 0; k < 8; k++) begin
      @(posedge i_clock);
      i_setup_byte_valid <= 1'b1;
      i_setup_byte       <= 8'h10 + 8'(k);
    end
    @(posedge i_clock);
    i_setup_byte_valid <= 1'b0;
    i_setup_done       <= 1'b1;
    @(posedge i_clock);
    i_setup_done <= 1'b0;
    tok(2'h0, 4'h0, 3'h2);
    tok(2'h3, 4'h0, 3'h2);
    rd(8'h59, 16'hffff, 16'h1312);
    rd(8'h00, 16'h0001, 16'h0001);
    rd(8'h0e, 16'h0013, 16'h0011);
    wr(8'h08, 16'h0040);
    rd(8'h08, 16'h0013, 16'h0001);
    wr(8'h01, 16'h0000);
    wr(8'h08, 16'h0003);
    tok(2'h0, 4'h0, 3'h3);
    wr(8'h08, 16'h0000);
    tok(2'h0, 4'h0, 3'h1);
    rd(8'h20, 16'h0004, 16'h0004);
    wr(8'h0e, 16'h0000);
    wr(8'h02, 16'h0003);
    tok(2'h1, 4'h0, 3'h4);
    chk("auto", 16'h0001, {15'h0000, o_reply_auto});
    @(posedge i_clock);
    i_desc_done <= 1'b1;
    @(posedge i_clock);
    i_desc_done <= 1'b0;
    rd(8'h20, 16'h0082, 16'h0082);
    wr(8'h11, 16'h0013);
    tok(2'h1, 4'h3, 3'h0);
    wr(8'h51, 16'h0001);
    tok(2'h1, 4'h3, 3'h2);
    @(posedge i_clock);
    i_area_has_pkt <= 6'h02;
    tok(2'h1, 4'h3, 3'h4);
    chk("area", 16'h0001, {13'h0000, o_reply_area});
    rd(8'h09, 16'h0010, 16'h0010);
    wr(8'h09, 16'h0004);
    i_area_has_pkt <= 6'h00;
    tok(2'h1, 4'h3, 3'h4);
    rd(8'h09, 16'h0004, 16'h0000);
    tok(2'h1, 4'h3, 3'h2);
    wr(8'h12, 16'h0024);
    wr(8'h13, 16'h0045);
    rd(8'h13, 16'h007f, 16'h0045);
    wr(8'h52, 16'h0002);
    wr(8'h2a, 16'h0001);
    tok(2'h0, 4'h4, 3'h1);
    rd(8'h0a, 16'h0001, 16'h0001);
    chk("irq", 16'h0001, {15'h0000, o_irq});
    wr(8'h22, 16'h0001);
    rd(8'h22, 16'h0001, 16'h0000);
    chk("irq", 16'h0000, {15'h0000, o_irq});
    wr(8'h31, 16'h8000);
    tok(2'h0, 4'hf, 3'h2);
    rd(8'h35, 16'hffff, 16'h8000);
    rd(8'h60, 16'hffff, 16'h0000);
    wrap_up;
  end
endmodule // ued_ctrl_tb_top
